// file: hdl/cdrm_bank.sv
// Control and diagnostic register bank with pump spread control
`timescale 1ns/1ps
`default_nettype none
`include "cdrm_map.svh"

// How it works
// - Spread enable modulates pump clock, else fixed
// - Pump near 52.1 kHz, energy spread around it
// - Hop field picks 1/2/4/8 clocks per hop
// - Access lock is read-only, loaded from NV
// - Checksum enable gates checksum diagnostic
// - NV write-lock refuses NV-mirror register writes
// - Main write-lock refuses main register writes
// - Reset codes 00h watchdog, 55h checksum, FFh latch
// - Register duty is high two bits over low
// - Status select picks the 24-bit status
// - Low status read freezes upper two bytes
module cdrm_bank (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  input  wire logic        nv_load_stb,
  input  wire logic [7:0]  nv_access_config_word,
  input  wire logic        motor_enable,
  input  wire logic        nv_busy_flag,
  input  wire logic        csum_error_event,
  input  wire logic [31:0] diag_flags_in,
  input  wire logic [15:0][23:0] status_sources,
  input  wire logic        duty_source_select,
  output logic      [9:0]  host_duty_input,
  output logic             brake_request,
  output logic      [15:0] aux_word,
  output logic             readback_enable,
  output logic             readback_level,
  output logic             checksum_check_enable,
  output logic             wdt_restart_pulse,
  output logic             latch_release_pulse,
  output logic             nv_download_pulse,
  output logic             nv_checksum_pulse,
  output logic             csum_error_flag,
  output logic             pump_switch_clock
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] en_s_q;
  logic [1:0] busy_s_q;
  logic [1:0] sel_s_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_s_q   <= 2'b00;
      busy_s_q <= 2'b00;
      sel_s_q  <= 2'b00;
    end else begin
      en_s_q   <= {en_s_q[0], motor_enable};
      busy_s_q <= {busy_s_q[0], nv_busy_flag};
      sel_s_q  <= {sel_s_q[0], duty_source_select};
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  spread_q;
  logic [7:0]  lock_q;
  logic [7:0]  duty_low_q;
  logic [7:0]  duty_high_q;
  logic [7:0]  ctl_a_q;
  logic [7:0]  ctl_b_q;
  logic [7:0]  ctl_c_q;
  logic [7:0]  status_source_select_q;
  logic [7:0]  aux_low_q;
  logic [7:0]  aux_high_q;
  logic [7:0]  readback_q;
  logic [15:0] stat_hold_q;
  logic        csum_err_q;

  logic main_wr_ok;
  logic nv_wr_ok;
  logic wr_main;
  logic wr_nv;
  logic [23:0] status_now;

  assign nv_wr_ok   = ~lock_q[`CDRM_LOCK_NV_BIT];
  assign main_wr_ok = ~lock_q[`CDRM_LOCK_MAIN_BIT];
  // A refused write only skips the store; the access itself completes normally
  assign wr_nv   = wr_stb && nv_wr_ok;
  assign wr_main = wr_stb && main_wr_ok;
  assign status_now = status_sources[status_source_select_q[3:0]];

  // Lock word only changes by the NV load, never from the host
  always_ff @(posedge sys_clk) begin
    if (rst)
      lock_q <= `CDRM_RST_VALUE;
    else if (nv_load_stb)
      lock_q <= nv_access_config_word & 8'h07;
  end

  // Pump spread register mirrors NV content
  always_ff @(posedge sys_clk) begin
    if (rst)
      spread_q <= `CDRM_RST_VALUE;
    else if (wr_nv && addr == `CDRM_ADDR_PUMP_SPREAD)
      spread_q <= wdata & `CDRM_SPREAD_WMASK;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      duty_low_q  <= `CDRM_RST_VALUE;
      duty_high_q <= `CDRM_RST_VALUE;
      ctl_a_q     <= `CDRM_RST_VALUE;
      ctl_b_q     <= `CDRM_RST_VALUE;
      ctl_c_q     <= `CDRM_RST_VALUE;
      status_source_select_q   <= `CDRM_RST_VALUE;
      aux_low_q   <= `CDRM_RST_VALUE;
      aux_high_q  <= `CDRM_RST_VALUE;
      readback_q  <= `CDRM_RST_VALUE;
    end else if (wr_main) begin
      case (addr)
        `CDRM_ADDR_DUTY_LOW:    duty_low_q  <= wdata;
        `CDRM_ADDR_DUTY_HIGH:   duty_high_q <= wdata & `CDRM_DUTY_HIGH_WMASK;
        `CDRM_ADDR_INT_CTL_A:   ctl_a_q     <= wdata;
        `CDRM_ADDR_INT_CTL_B:   ctl_b_q     <= wdata;
        `CDRM_ADDR_INT_CTL_C:   ctl_c_q     <= wdata & 8'h03;
        `CDRM_ADDR_STATUS_SEL:  status_source_select_q   <= wdata & `CDRM_STATUS_SOURCE_SELECT_WMASK;
        `CDRM_ADDR_AUX_LOW:     aux_low_q   <= wdata;
        `CDRM_ADDR_AUX_HIGH:    aux_high_q  <= wdata;
        `CDRM_ADDR_NV_READBACK: readback_q  <= wdata & `CDRM_READBACK_WMASK;
        default:                ;
      endcase
    end
  end

  // ****************************************
  // Commands
  // ****************************************
  // Reset codes are taken at any time; the lock bits do not apply to commands
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wdt_restart_pulse   <= 1'b0;
      latch_release_pulse <= 1'b0;
    end else begin
      wdt_restart_pulse   <= wr_stb && addr == `CDRM_ADDR_RESET_CMD
                             && wdata == `CDRM_CMD_WDT_RESTART;
      latch_release_pulse <= wr_stb && addr == `CDRM_ADDR_RESET_CMD
                             && wdata == `CDRM_CMD_LATCH_RELEASE;
    end
  end

  // Host must keep the enable low and NV idle; a write otherwise is dropped as a guard
  logic nv_cmd_ok;
  assign nv_cmd_ok = wr_stb && addr == `CDRM_ADDR_NV_CMD && !en_s_q[1] && !busy_s_q[1];
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nv_download_pulse <= 1'b0;
      nv_checksum_pulse <= 1'b0;
    end else begin
      nv_download_pulse <= nv_cmd_ok && wdata == `CDRM_CMD_NV_DOWNLOAD;
      nv_checksum_pulse <= nv_cmd_ok && wdata == `CDRM_CMD_NV_CHECKSUM;
    end
  end

  // Checksum error: new error wins over clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst)
      csum_err_q <= 1'b0;
    else if (csum_error_event && lock_q[`CDRM_LOCK_CSUM_BIT])
      csum_err_q <= 1'b1;
    else if (wr_stb && addr == `CDRM_ADDR_RESET_CMD && wdata == `CDRM_CMD_CSUM_CLEAR)
      csum_err_q <= 1'b0;
  end

  // ****************************************
  // Read path
  // ****************************************
  // Hold keeps bytes 1 and 2 coherent with byte 0
  always_ff @(posedge sys_clk) begin
    if (rst)
      stat_hold_q <= 16'h0000;
    else if (rd_stb && addr == `CDRM_ADDR_STATUS0)
      stat_hold_q <= status_now[23:8];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        `CDRM_ADDR_PUMP_SPREAD:  rdata <= spread_q;
        `CDRM_ADDR_ACCESS_LOCK:  rdata <= lock_q;
        `CDRM_ADDR_DIAG0:        rdata <= diag_flags_in[7:0];
        `CDRM_ADDR_DIAG1:        rdata <= diag_flags_in[15:8] | {2'b00, csum_err_q, 5'b0_0000};
        `CDRM_ADDR_DIAG2:        rdata <= diag_flags_in[23:16] & 8'h3F;
        `CDRM_ADDR_DIAG3:        rdata <= diag_flags_in[31:24] & 8'h03;
        `CDRM_ADDR_STATUS0:      rdata <= status_now[7:0];
        `CDRM_ADDR_STATUS1:      rdata <= stat_hold_q[7:0];
        `CDRM_ADDR_STATUS2:      rdata <= stat_hold_q[15:8];
        `CDRM_ADDR_DUTY_LOW:     rdata <= duty_low_q;
        `CDRM_ADDR_DUTY_HIGH:    rdata <= duty_high_q;
        `CDRM_ADDR_INT_CTL_A:    rdata <= ctl_a_q;
        `CDRM_ADDR_INT_CTL_B:    rdata <= ctl_b_q;
        `CDRM_ADDR_INT_CTL_C:    rdata <= ctl_c_q;
        `CDRM_ADDR_STATUS_SEL:   rdata <= status_source_select_q;
        `CDRM_ADDR_AUX_LOW:      rdata <= aux_low_q;
        `CDRM_ADDR_AUX_HIGH:     rdata <= aux_high_q;
        `CDRM_ADDR_NV_READBACK:  rdata <= readback_q;
        default:                 rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Duty word is zero when the pin path is chosen, so it never carries stale data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_duty_input       <= 10'h000;
      brake_request         <= 1'b0;
      aux_word              <= 16'h0000;
      readback_enable       <= 1'b0;
      readback_level        <= 1'b0;
      checksum_check_enable <= 1'b0;
      csum_error_flag       <= 1'b0;
    end else begin
      host_duty_input       <= sel_s_q[1] ? {duty_high_q[1:0], duty_low_q} : 10'h000;
      brake_request         <= duty_high_q[`CDRM_BRAKE_BIT];
      aux_word              <= {aux_high_q, aux_low_q};
      readback_enable       <= readback_q[1];
      readback_level        <= readback_q[0];
      checksum_check_enable <= lock_q[`CDRM_LOCK_CSUM_BIT];
      csum_error_flag       <= csum_err_q;
    end
  end

  // ****************************************
  // Pump clock
  // ****************************************
  cdrm_pump_if pump_bus ();
  assign pump_bus.spread_en = spread_q[`CDRM_SPREAD_EN_BIT];
  assign pump_bus.hop = cdrm_pkg::cdrm_hop_t'(spread_q[`CDRM_HOP_MSB:`CDRM_HOP_LSB]);

  cdrm_pump_gen u_pump (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pump    (pump_bus.gen)
  );

  always_ff @(posedge sys_clk) begin
    if (rst)
      pump_switch_clock <= 1'b0;
    else
      pump_switch_clock <= pump_bus.pump_clk;
  end
endmodule : cdrm_bank
`default_nettype wire

// file: hdl/cdrm_map.svh
// Register offsets, field positions, reset values, command codes and clock frequencies of the control and diagnostic bank
`ifndef CDRM_MAP_SVH
`define CDRM_MAP_SVH

`define CDRM_ADDR_PUMP_SPREAD    12'h010F
`define CDRM_ADDR_ACCESS_LOCK    12'h0200
`define CDRM_ADDR_DIAG0          12'h0201
`define CDRM_ADDR_DIAG1          12'h0202
`define CDRM_ADDR_DIAG2          12'h0203
`define CDRM_ADDR_DIAG3          12'h0204
`define CDRM_ADDR_STATUS0        12'h0205
`define CDRM_ADDR_STATUS1        12'h0206
`define CDRM_ADDR_STATUS2        12'h0207
`define CDRM_ADDR_RESET_CMD      12'h0300
`define CDRM_ADDR_DUTY_LOW       12'h0301
`define CDRM_ADDR_DUTY_HIGH      12'h0302
`define CDRM_ADDR_INT_CTL_A      12'h0303
`define CDRM_ADDR_INT_CTL_B      12'h0304
`define CDRM_ADDR_INT_CTL_C      12'h0305
`define CDRM_ADDR_STATUS_SEL     12'h0306
`define CDRM_ADDR_AUX_LOW        12'h0307
`define CDRM_ADDR_AUX_HIGH       12'h0308
`define CDRM_ADDR_NV_CMD         12'h0400
`define CDRM_ADDR_NV_READBACK    12'h0401

`define CDRM_SPREAD_EN_BIT       4
`define CDRM_HOP_MSB             3
`define CDRM_HOP_LSB             2
`define CDRM_SPREAD_WMASK        8'h1C
`define CDRM_LOCK_CSUM_BIT       2
`define CDRM_LOCK_NV_BIT         1
`define CDRM_LOCK_MAIN_BIT       0
`define CDRM_BRAKE_BIT           7
`define CDRM_DUTY_HIGH_WMASK     8'h83
`define CDRM_STATUS_SOURCE_SELECT_WMASK       8'h0F
`define CDRM_READBACK_WMASK      8'h03
`define CDRM_DIAG1_CSUM_BIT      5

`define CDRM_RST_VALUE           8'h00

`define CDRM_CMD_WDT_RESTART     8'h00
`define CDRM_CMD_CSUM_CLEAR      8'h55
`define CDRM_CMD_LATCH_RELEASE   8'hFF
`define CDRM_CMD_NV_DOWNLOAD     8'h00
`define CDRM_CMD_NV_CHECKSUM     8'h01

`define CDRM_PUMP_FREQ_HZ        52100
`define CDRM_SYS_FREQ_HZ         10000000

`endif

// file: hdl/cdrm_pkg.sv
// Types shared by the control and diagnostic bank
package cdrm_pkg;
  typedef enum logic [1:0] {
    CDRM_HOP_1 = 2'b00,
    CDRM_HOP_2 = 2'b01,
    CDRM_HOP_4 = 2'b10,
    CDRM_HOP_8 = 2'b11
  } cdrm_hop_t;
endpackage : cdrm_pkg

// file: hdl/cdrm_pump_gen.sv
// Charge pump switch clock generator with optional spread spectrum
`timescale 1ns/1ps
`default_nettype none
`include "cdrm_map.svh"
module cdrm_pump_gen #(
  parameter int HALF_NOM = `CDRM_SYS_FREQ_HZ / (2 * `CDRM_PUMP_FREQ_HZ),
  parameter int SPREAD   = 8
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  cdrm_pump_if.gen  pump
);
  initial begin
    if (HALF_NOM <= SPREAD || SPREAD < 1 || SPREAD > 15 || HALF_NOM > 1000)
      $error("cdrm_pump_gen: bad period parameters");
  end

  logic [9:0] cnt_q;
  logic [3:0] offs_q;
  logic       up_q;
  logic [2:0] hop_cnt_q;
  logic [9:0] half_len;
  logic       half_done;
  logic [2:0] hop_lim;
  logic       clk_q;

  // Spread varies the half period around nominal, stepping a triangle offset
  assign half_len  = pump.spread_en ? 10'(HALF_NOM - SPREAD/2) + 10'(offs_q) : 10'(HALF_NOM);
  assign half_done = (cnt_q >= half_len - 10'd1);

  always_comb begin
    case (pump.hop)
      cdrm_pkg::CDRM_HOP_1: hop_lim = 3'd0;
      cdrm_pkg::CDRM_HOP_2: hop_lim = 3'd1;
      cdrm_pkg::CDRM_HOP_4: hop_lim = 3'd3;
      cdrm_pkg::CDRM_HOP_8: hop_lim = 3'd7;
      default:              hop_lim = 3'd0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 10'd0;
      clk_q <= 1'b0;
    end else if (half_done) begin
      cnt_q <= 10'd0;
      clk_q <= ~clk_q;
    end else begin
      cnt_q <= cnt_q + 10'd1;
    end
  end

  // Frequency hops once per 1, 2, 4 or 8 whole pump clocks
  always_ff @(posedge sys_clk) begin
    if (rst || !pump.spread_en) begin
      hop_cnt_q <= 3'd0;
      offs_q    <= 4'd0;
      up_q      <= 1'b1;
    end else if (half_done && clk_q) begin
      if (hop_cnt_q >= hop_lim) begin
        hop_cnt_q <= 3'd0;
        if (up_q && offs_q >= 4'(SPREAD))
          up_q <= 1'b0;
        else if (!up_q && offs_q == 4'd0)
          up_q <= 1'b1;
        else if (up_q)
          offs_q <= offs_q + 4'd1;
        else
          offs_q <= offs_q - 4'd1;
      end else begin
        hop_cnt_q <= hop_cnt_q + 3'd1;
      end
    end
  end

  assign pump.pump_clk = clk_q;
endmodule : cdrm_pump_gen
`default_nettype wire

// file: hdl/cdrm_pump_if.sv
// Interface between the register bank and the pump clock generator
`timescale 1ns/1ps
`default_nettype none
interface cdrm_pump_if;
  logic              spread_en;
  cdrm_pkg::cdrm_hop_t hop;
  logic              pump_clk;
  modport ctl (output spread_en, output hop, input pump_clk);
  modport gen (input spread_en, input hop, output pump_clk);
endinterface : cdrm_pump_if
`default_nettype wire

// file: sim/cdrm_bank_sva.sv
// Port checker for the control and diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module cdrm_bank_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [11:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        motor_enable,
  input wire logic        csum_error_event,
  input wire logic        csum_error_flag,
  input wire logic [15:0] aux_word,
  input wire logic        wdt_restart_pulse,
  input wire logic        latch_release_pulse,
  input wire logic        nv_download_pulse,
  input wire logic        pump_switch_clock
);
  // ****************
  // Checks
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       pump_q;
  logic       seen_q;
  logic [7:0] gap_q;
  // Cycles since the last pump toggle; the first half after reset is not judged
  always_ff @(posedge sys_clk) begin
    pump_q <= pump_switch_clock;
    gap_q  <= (rst || pump_q != pump_switch_clock) ? 8'h00 : gap_q + 8'h01;
  end
  always_ff @(posedge sys_clk) begin
    seen_q <= rst ? 1'b0 : (seen_q || pump_q != pump_switch_clock);
  end
  sequence s_cmd(a, d);
    wr_stb && addr == a && wdata == d;
  endsequence
  AST_WDT: assert property (s_cmd(12'h300, 8'h00) |=> wdt_restart_pulse)
    else $error("watchdog restart pulse missing");
  AST_LATCH: assert property (s_cmd(12'h300, 8'hFF) |=> latch_release_pulse)
    else $error("latch release pulse missing");
  AST_WDT_CAUSE: assert property ($rose(wdt_restart_pulse) |->
    $past(wr_stb) && $past(addr) == 12'h300 && $past(wdata) == 8'h00) else $error("stray watchdog pulse");
  AST_CSUM_CLR: assert property (s_cmd(12'h300, 8'h55) ##0 !csum_error_event |-> ##2 !csum_error_flag)
    else $error("checksum error not cleared");
  AST_CSUM_SET: assert property ($rose(csum_error_flag) |-> $past(csum_error_event, 2))
    else $error("checksum flag set without event");
  AST_NV_DL: assert property (nv_download_pulse |->
    $past(wr_stb) && $past(addr) == 12'h400 && $past(wdata) == 8'h00) else $error("stray download pulse");
  AST_NV_BLOCK: assert property (motor_enable [*3] ##0 s_cmd(12'h400, 8'h00) |=> !nv_download_pulse)
    else $error("download ran while enabled");
  AST_AUX: assert property ($changed(aux_word) |-> $past(wr_stb) || $past(wr_stb, 2))
    else $error("aux word changed without a write");
  AST_RDATA: assert property ($changed(rdata) |-> $past(rd_stb))
    else $error("read data changed without a read");
  AST_PUMP_HALF: assert property ((pump_q != pump_switch_clock) && seen_q |-> gap_q inside {[8'h5A:8'h62]})
    else $error("pump half period out of range");
  AST_PUMP_MAX: assert property (gap_q <= 8'h62)
    else $error("pump clock stalled");
endmodule : cdrm_bank_chk
bind cdrm_bank cdrm_bank_chk u_chk (.sys_clk, .rst, .wr_stb, .rd_stb, .addr, .wdata, .rdata, .motor_enable,
  .csum_error_event, .csum_error_flag, .aux_word, .wdt_restart_pulse, .latch_release_pulse, .nv_download_pulse,
  .pump_switch_clock);
`default_nettype wire

// file: sim/cdrm_host.sv
// Host model issuing register writes and reads on the strobe bus
`timescale 1ns/1ps
`default_nettype none
module cdrm_host (
  input  wire logic        sys_clk,
  output var  logic        wr_stb,
  output var  logic        rd_stb,
  output var  logic [11:0] addr,
  output var  logic [7:0]  wdata,
  input  wire logic [7:0]  rdata
);
  // ****************
  // Bus cycles
  // ****************
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr   = 12'h000;
    wdata  = 8'h00;
  end
  // Codes pass untouched nv_command only when idle unless a refusal is probed
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    // Released lines show junk so a stale value is never mistaken for a request
    addr   <= ~a;
    wdata  <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    addr   <= ~a;
    #1;
    d = rdata;
  endtask : rd
endmodule : cdrm_host
`default_nettype wire

// file: sim/control_diag_register_map_tb.sv
// Self-checking bench for the control and diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module control_diag_register_map_tb;
  typedef struct packed { logic [11:0] a; logic [7:0] w; logic [7:0] e; } cdrm_row_t;
  localparam cdrm_row_t ROWS [0:10] = '{'{12'h301, 8'h5A, 8'h5A}, '{12'h302, 8'hFF, 8'h83},
    '{12'h306, 8'hFF, 8'h0F}, '{12'h307, 8'hA5, 8'hA5}, '{12'h308, 8'h3C, 8'h3C}, '{12'h401, 8'hFF, 8'h03},
    '{12'h10F, 8'hFF, 8'h1C}, '{12'h305, 8'hFF, 8'h03}, '{12'h200, 8'hFF, 8'h00}, '{12'h201, 8'hFF, 8'h08},
    '{12'h500, 8'hFF, 8'h00}};
  logic sys_clk = 1'b0, rst = 1'b1, wr_stb, rd_stb, nv_load_stb = 1'b0, motor_enable = 1'b0;
  logic nv_busy_flag = 1'b0, csum_error_event = 1'b0, duty_source_select = 1'b1;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, v, nv_access_config_word = 8'h00;
  logic [31:0] diag_flags_in = 32'h0102_0408;
  logic [15:0][23:0] status_sources = '0;
  logic [9:0]  host_duty_input;
  logic [15:0] aux_word;
  logic brake_request, readback_enable, readback_level, checksum_check_enable, wdt_restart_pulse;
  logic latch_release_pulse, nv_download_pulse, nv_checksum_pulse, csum_error_flag, pump_switch_clock;
  int failures = 0, checks = 0, n, lo, hi;
  always #50 sys_clk = ~sys_clk;
  cdrm_host u_host (.sys_clk, .wr_stb, .rd_stb, .addr, .wdata, .rdata);
  cdrm_bank u_dut (.sys_clk, .rst, .wr_stb, .rd_stb, .addr, .wdata, .rdata, .nv_load_stb,
    .nv_access_config_word, .motor_enable, .nv_busy_flag, .csum_error_event, .diag_flags_in, .status_sources,
    .duty_source_select, .host_duty_input, .brake_request, .aux_word, .readback_enable, .readback_level,
    .checksum_check_enable, .wdt_restart_pulse, .latch_release_pulse, .nv_download_pulse, .nv_checksum_pulse,
    .csum_error_flag, .pump_switch_clock);
  // ****************
  // Helpers
  // ****************
  task automatic final_report;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : tick
  // Length of one pump half period; a stalled clock ends the run
  task automatic half(output int h);
    logic p;
    h = 0;
    p = pump_switch_clock;
    for (int i = 0; i < 300 && pump_switch_clock === p; i++) @(posedge sys_clk);
    p = pump_switch_clock;
    while (h < 300 && pump_switch_clock === p) begin
      @(posedge sys_clk);
      h++;
    end
    if (h >= 300) begin
      failures++;
      final_report();
    end
  endtask : half
  task automatic pulse_event;
    @(posedge sys_clk) csum_error_event <= 1'b1;
    @(posedge sys_clk) csum_error_event <= 1'b0;
    tick(3);
  endtask : pulse_event
  initial begin
    tick(6);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      u_host.wr(ROWS[i].a, ROWS[i].w);
      u_host.rd(ROWS[i].a, v);
      chk(v, ROWS[i].e);
    end
    chk(16'(host_duty_input), 16'h035A);
    chk({brake_request, readback_enable, readback_level, aux_word}, 19'h7_3CA5);
    // Upper status bytes must come from the sample taken at the low byte read
    status_sources[3] <= 24'h11_2233;
    u_host.wr(12'h306, 8'h03);
    u_host.rd(12'h205, v);
    chk(v, 8'h33);
    status_sources[3] <= 24'hAA_BBCC;
    u_host.rd(12'h206, v);
    chk(v, 8'h22);
    u_host.rd(12'h207, v);
    chk(v, 8'h11);
    u_host.wr(12'h10F, 8'h00);
    half(n);
    half(n);
    chk(n, 95);
    for (int h = 0; h < 4; h++) begin
      u_host.wr(12'h10F, {3'h0, 1'b1, 2'(h), 2'h0});
      lo = 999;
      hi = 0;
      // Offset state carries over between hop codes, so watch long enough for two hops at the slowest code
      repeat (40) begin
        half(n);
        lo = (n < lo) ? n : lo;
        hi = (n > hi) ? n : hi;
      end
      chk(lo >= 91 && hi <= 99 && hi != lo, 1);
    end
    u_host.wr(12'h10F, 8'h00);
    pulse_event();
    chk(csum_error_flag, 1'b0);
    u_host.wr(12'h400, 8'h00);
    chk(nv_download_pulse, 1'b1);
    u_host.wr(12'h400, 8'h01);
    chk(nv_checksum_pulse, 1'b1);
    motor_enable <= 1'b1;
    tick(3);
    u_host.wr(12'h400, 8'h00);
    chk(nv_download_pulse, 1'b0);
    motor_enable <= 1'b0;
    nv_busy_flag <= 1'b1;
    tick(3);
    u_host.wr(12'h400, 8'h01);
    chk(nv_checksum_pulse, 1'b0);
    nv_busy_flag <= 1'b0;
    foreach (ROWS[i]) begin
      if (i < 3) begin
        v = (i == 0) ? 8'h00 : (i == 1) ? 8'h55 : 8'hFF;
        u_host.wr(12'h300, v);
        chk({wdt_restart_pulse, latch_release_pulse}, {v == 8'h00, v == 8'hFF});
      end
    end
    // Load all three lock bits, then probe refused writes
    nv_access_config_word <= 8'h07;
    nv_load_stb <= 1'b1;
    @(posedge sys_clk) nv_load_stb <= 1'b0;
    u_host.rd(12'h200, v);
    chk(v, 8'h07);
    chk(checksum_check_enable, 1'b1);
    u_host.wr(12'h301, 8'h00);
    u_host.wr(12'h10F, 8'h1C);
    u_host.rd(12'h301, v);
    chk(v, 8'h5A);
    u_host.rd(12'h10F, v);
    chk(v, 8'h00);
    u_host.wr(12'h300, 8'hFF);
    chk(latch_release_pulse, 1'b1);
    pulse_event();
    chk(csum_error_flag, 1'b1);
    u_host.rd(12'h202, v);
    chk(v, 8'h24);
    u_host.wr(12'h300, 8'h55);
    tick(2);
    chk(csum_error_flag, 1'b0);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    u_host.rd(12'h200, v);
    chk({v, host_duty_input, brake_request}, 19'h0);
    final_report();
  end
endmodule : control_diag_register_map_tb
`default_nettype wire
